/* tci_defs.vh */
// constants for the timer, capture and interrupt source block
`ifndef TCI_DEFS_VH
`define TCI_DEFS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TCI_CLK_PERIOD_NS   5
`define TCI_TICK_PERIOD_NS  1000
`define TCI_TICK_CYCLES     (`TCI_TICK_PERIOD_NS / `TCI_CLK_PERIOD_NS)
`define TCI_TIMER_W         12
`define TCI_PRESC_W         8
`define TCI_P128_MSB        6
`define TCI_P1024_MSB       9
`define TCI_SLICE_MAX       3'h4

// ----------------------------------------------------------------
// register offsets (8-bit data)
// ----------------------------------------------------------------
`define TCI_ADDR_W          8
`define TCI_REG_TIMER_LO    8'h00
`define TCI_REG_TIMER_HI    8'h01
`define TCI_REG_CAP_A_RISE  8'h02
`define TCI_REG_CAP_A_FALL  8'h03
`define TCI_REG_CAP_B_RISE  8'h04
`define TCI_REG_CAP_B_FALL  8'h05
`define TCI_REG_CAP_CFG     8'h06
`define TCI_REG_CAP_STAT    8'h07
`define TCI_REG_IRQ_STAT_LO 8'h08
`define TCI_REG_IRQ_STAT_HI 8'h09
`define TCI_REG_IRQ_MASK_LO 8'h0a
`define TCI_REG_IRQ_MASK_HI 8'h0b
`define TCI_REG_P0_MASK     8'h0c
`define TCI_REG_P1_MASK     8'h0d
`define TCI_REG_P0_POL      8'h0e
`define TCI_REG_P1_POL      8'h0f
`define TCI_REG_P0_PINS     8'h10
`define TCI_REG_P1_PINS     8'h11

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TCI_CFG_SLICE_LSB   0
`define TCI_CFG_SLICE_MSB   2
`define TCI_CFG_EN_A_RISE   4
`define TCI_CFG_EN_A_FALL   5
`define TCI_CFG_EN_B_RISE   6
`define TCI_CFG_EN_B_FALL   7
`define TCI_CFG_RESET       8'h00
`define TCI_MASK_RESET      10'h000
`define TCI_PMASK_RESET     8'h00
`define TCI_POL_RESET       8'h00

// interrupt source bit positions
`define TCI_NUM_SRC         10
`define TCI_SRC_BUS_RESET   0
`define TCI_SRC_T128        1
`define TCI_SRC_T1024       2
`define TCI_SRC_EP0         3
`define TCI_SRC_EP1         4
`define TCI_SRC_EP2         5
`define TCI_SRC_CAP_A       6
`define TCI_SRC_CAP_B       7
`define TCI_SRC_WAKE        8
`define TCI_SRC_GPIO        9

`endif

/* tci_sync.v */
// three-stage pin synchroniser with agreement filter
module tci_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         mclk,
   input  wire         nrst,
   // pins in, filtered level out
   input  wire [W-1:0] pin_in,
   output wire [W-1:0] level_out
);

   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   reg [W-1:0] level_r;

   // shift chain; level follows only when stage two and three agree
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_r    <= {W{1'b0}};
         s2_r    <= {W{1'b0}};
         s3_r    <= {W{1'b0}};
         level_r <= {W{1'b0}};
      end else begin
         s1_r    <= pin_in;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         level_r <= (s2_r & s3_r) | (level_r & (s2_r ^ s3_r));
      end
   end

   assign level_out = level_r;

endmodule

/* tci_top.v */
// free-running timer, capture channels and interrupt source collection
`include "tci_defs.vh"

module tci_top (
   // clock and reset
   input  wire                    mclk,
   input  wire                    nrst,
   // register port
   input  wire [`TCI_ADDR_W-1:0]  reg_addr,
   input  wire [7:0]              reg_wdata,
   input  wire                    reg_we,
   input  wire                    reg_re,
   output wire [7:0]              reg_rdata,
   // general-purpose pins
   input  wire [7:0]              port_zero_pins,
   input  wire [7:0]              port_one_pins,
   // event pulses from neighbouring logic
   input  wire                    bus_reset_evt,
   input  wire [2:0]              ep_done_evt,
   input  wire                    wake_evt,
   // interrupt and status out
   output wire                    irq,
   output wire [9:0]              irq_pending,
   output wire [`TCI_TIMER_W-1:0] timer_value
);

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   wire [15:0] pins_sync;
   reg  [15:0] pins_prev_r;

   // one synchroniser for all sixteen pins
   tci_sync #(
      .W         (16)
   ) u_sync (
      .mclk      (mclk),
      .nrst      (nrst),
      .pin_in    ({port_one_pins, port_zero_pins}),
      .level_out (pins_sync)
   );

   // previous filtered level for edge detection
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pins_prev_r <= 16'h0000;
      end else begin
         pins_prev_r <= pins_sync;
      end
   end

   wire [15:0] pin_rise = pins_sync & ~pins_prev_r;
   wire [15:0] pin_fall = ~pins_sync & pins_prev_r;

   // ----------------------------------------------------------------
   // 1 MHz tick and free-running timer
   // ----------------------------------------------------------------
   localparam integer            TICK_LAST_I = `TCI_TICK_CYCLES - 1;
   localparam [`TCI_PRESC_W-1:0] TICK_LAST   = TICK_LAST_I[`TCI_PRESC_W-1:0];

   reg  [`TCI_PRESC_W-1:0] presc_r;
   reg  [`TCI_TIMER_W-1:0] timer_r;
   wire                    tick = (presc_r == TICK_LAST);

   // prescaler divides the system clock down to the timer tick
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         presc_r <= {`TCI_PRESC_W{1'b0}};
      end else if (tick) begin
         presc_r <= {`TCI_PRESC_W{1'b0}};
      end else begin
         presc_r <= presc_r + 8'h01;
      end
   end

   // counter runs with no start or stop control
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timer_r <= {`TCI_TIMER_W{1'b0}};
      end else if (tick) begin
         timer_r <= timer_r + 12'h001; // wraps to zero
      end
   end

   assign timer_value = timer_r;

   // periodic events on the tick that flips the period bit back to zero
   wire evt_t128  = tick & (&timer_r[`TCI_P128_MSB:0]);
   wire evt_t1024 = tick & (&timer_r[`TCI_P1024_MSB:0]);

   // ----------------------------------------------------------------
   // capture channels
   // ----------------------------------------------------------------
   reg  [7:0] cap_cfg_r;
   reg  [7:0] cap_val_r [0:3];
   reg  [3:0] cap_stat_r;
   wire [2:0] slice_raw = cap_cfg_r[`TCI_CFG_SLICE_MSB:`TCI_CFG_SLICE_LSB];
   wire [2:0] slice_sel = (slice_raw > `TCI_SLICE_MAX) ? `TCI_SLICE_MAX : slice_raw;
   wire [`TCI_TIMER_W-1:0] timer_shift = timer_r >> slice_sel;
   wire [7:0] cap_slice = timer_shift[7:0];

   // capture strobes: a rise, a fall, b rise, b fall
   wire [3:0] cap_hit;
   assign cap_hit[0] = pin_rise[0] & cap_cfg_r[`TCI_CFG_EN_A_RISE];
   assign cap_hit[1] = pin_fall[0] & cap_cfg_r[`TCI_CFG_EN_A_FALL];
   assign cap_hit[2] = pin_rise[1] & cap_cfg_r[`TCI_CFG_EN_B_RISE];
   assign cap_hit[3] = pin_fall[1] & cap_cfg_r[`TCI_CFG_EN_B_FALL];

   wire wr_cap_stat = reg_we & (reg_addr == `TCI_REG_CAP_STAT);

   // one register per channel and edge
   genvar ci;
   generate
      for (ci = 0; ci < 4; ci = ci + 1) begin : g_cap
         always @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               cap_val_r[ci]  <= 8'h00;
               cap_stat_r[ci] <= 1'b0;
            end else begin
               if (cap_hit[ci]) begin
                  cap_val_r[ci] <= cap_slice;
               end
               // new capture beats a write-one clear
               if (cap_hit[ci]) begin
                  cap_stat_r[ci] <= 1'b1;
               end else if (wr_cap_stat & reg_wdata[ci]) begin
                  cap_stat_r[ci] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   wire evt_cap_a = cap_hit[0] | cap_hit[1];
   wire evt_cap_b = cap_hit[2] | cap_hit[3];

   // ----------------------------------------------------------------
   // shared gpio interrupt
   // ----------------------------------------------------------------
   reg  [15:0] pin_mask_r;
   reg  [15:0] pin_pol_r;
   wire [15:0] pin_trig;

   // per pin: chosen edge, gated by the pin mask
   genvar pi;
   generate
      for (pi = 0; pi < 16; pi = pi + 1) begin : g_pin
         assign pin_trig[pi] = pin_mask_r[pi] &
                               (pin_pol_r[pi] ? pin_rise[pi] : pin_fall[pi]);
      end
   endgenerate

   wire evt_gpio = |pin_trig;

   // ----------------------------------------------------------------
   // interrupt status and mask
   // ----------------------------------------------------------------
   reg  [9:0] irq_stat_r;
   reg  [9:0] irq_mask_r;
   wire [9:0] src_evt;

   // endpoint inputs are completion pulses, so they set status only when done
   assign src_evt[`TCI_SRC_BUS_RESET] = bus_reset_evt;
   assign src_evt[`TCI_SRC_T128]      = evt_t128 & irq_mask_r[`TCI_SRC_T128];
   assign src_evt[`TCI_SRC_T1024]     = evt_t1024 & irq_mask_r[`TCI_SRC_T1024];
   assign src_evt[`TCI_SRC_EP0]       = ep_done_evt[0];
   assign src_evt[`TCI_SRC_EP1]       = ep_done_evt[1];
   assign src_evt[`TCI_SRC_EP2]       = ep_done_evt[2];
   assign src_evt[`TCI_SRC_CAP_A]     = evt_cap_a;
   assign src_evt[`TCI_SRC_CAP_B]     = evt_cap_b;
   assign src_evt[`TCI_SRC_WAKE]      = wake_evt;
   assign src_evt[`TCI_SRC_GPIO]      = evt_gpio;

   // write-one-clear pattern across both status bytes
   wire [9:0] stat_clr;
   assign stat_clr[7:0] = (reg_we && reg_addr == `TCI_REG_IRQ_STAT_LO) ? reg_wdata : 8'h00;
   assign stat_clr[9:8] = (reg_we && reg_addr == `TCI_REG_IRQ_STAT_HI) ? reg_wdata[1:0]
                                                                       : 2'h0;

   // sticky status, set wins over clear
   genvar si;
   generate
      for (si = 0; si < `TCI_NUM_SRC; si = si + 1) begin : g_src
         always @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
               irq_stat_r[si] <= 1'b0;
            end else if (src_evt[si]) begin
               irq_stat_r[si] <= 1'b1;
            end else if (stat_clr[si]) begin
               irq_stat_r[si] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq_pending = irq_stat_r & irq_mask_r;
   assign irq         = |irq_pending;

   // ----------------------------------------------------------------
   // control registers written by software
   // ----------------------------------------------------------------
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cap_cfg_r  <= `TCI_CFG_RESET;
         irq_mask_r <= `TCI_MASK_RESET;
         pin_mask_r <= {`TCI_PMASK_RESET, `TCI_PMASK_RESET};
         pin_pol_r  <= {`TCI_POL_RESET, `TCI_POL_RESET};
      end else if (reg_we) begin
         case (reg_addr)
            `TCI_REG_CAP_CFG: begin
               cap_cfg_r <= reg_wdata;
            end
            `TCI_REG_IRQ_MASK_LO: begin
               irq_mask_r[7:0] <= reg_wdata;
            end
            `TCI_REG_IRQ_MASK_HI: begin
               irq_mask_r[9:8] <= reg_wdata[1:0];
            end
            `TCI_REG_P0_MASK: begin
               pin_mask_r[7:0] <= reg_wdata;
            end
            `TCI_REG_P1_MASK: begin
               pin_mask_r[15:8] <= reg_wdata;
            end
            `TCI_REG_P0_POL: begin
               pin_pol_r[7:0] <= reg_wdata;
            end
            `TCI_REG_P1_POL: begin
               pin_pol_r[15:8] <= reg_wdata;
            end
            default: begin
               cap_cfg_r <= cap_cfg_r;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // timer snapshot for a coherent two-byte read
   // ----------------------------------------------------------------
   reg [3:0] timer_hi_snap_r;

   // reading the low byte freezes the high nibble of the same moment
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         timer_hi_snap_r <= 4'h0;
      end else if (reg_re && reg_addr == `TCI_REG_TIMER_LO) begin
         timer_hi_snap_r <= timer_r[11:8];
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   reg [7:0] rd_mux;
   reg [7:0] rdata_r;

   // select readback by address; unmapped reads give zero
   always @* begin
      rd_mux = 8'h00;
      case (reg_addr)
         `TCI_REG_TIMER_LO: begin
            rd_mux = timer_r[7:0];
         end
         `TCI_REG_TIMER_HI: begin
            rd_mux = {4'h0, timer_hi_snap_r};
         end
         `TCI_REG_CAP_A_RISE: begin
            rd_mux = cap_val_r[0];
         end
         `TCI_REG_CAP_A_FALL: begin
            rd_mux = cap_val_r[1];
         end
         `TCI_REG_CAP_B_RISE: begin
            rd_mux = cap_val_r[2];
         end
         `TCI_REG_CAP_B_FALL: begin
            rd_mux = cap_val_r[3];
         end
         `TCI_REG_CAP_CFG: begin
            rd_mux = cap_cfg_r;
         end
         `TCI_REG_CAP_STAT: begin
            rd_mux = {4'h0, cap_stat_r};
         end
         `TCI_REG_IRQ_STAT_LO: begin
            rd_mux = irq_stat_r[7:0];
         end
         `TCI_REG_IRQ_STAT_HI: begin
            rd_mux = {6'h00, irq_stat_r[9:8]};
         end
         `TCI_REG_IRQ_MASK_LO: begin
            rd_mux = irq_mask_r[7:0];
         end
         `TCI_REG_IRQ_MASK_HI: begin
            rd_mux = {6'h00, irq_mask_r[9:8]};
         end
         `TCI_REG_P0_MASK: begin
            rd_mux = pin_mask_r[7:0];
         end
         `TCI_REG_P1_MASK: begin
            rd_mux = pin_mask_r[15:8];
         end
         `TCI_REG_P0_POL: begin
            rd_mux = pin_pol_r[7:0];
         end
         `TCI_REG_P1_POL: begin
            rd_mux = pin_pol_r[15:8];
         end
         `TCI_REG_P0_PINS: begin
            rd_mux = pins_sync[7:0];
         end
         `TCI_REG_P1_PINS: begin
            rd_mux = pins_sync[15:8];
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 8'h00;
      end else if (reg_re) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata = rdata_r;

endmodule

/* tci_top_properties.sv */
// port-level checker for the timer, capture and interrupt block
`include "tci_defs.vh"
module tci_top_properties (
   // clock and reset
   input logic                    mclk,
   input logic                    nrst,
   // register port
   input logic [`TCI_ADDR_W-1:0]  reg_addr,
   input logic [7:0]              reg_wdata,
   input logic                    reg_we,
   input logic                    reg_re,
   input logic [7:0]              reg_rdata,
   // events and outputs
   input logic [2:0]              ep_done_evt,
   input logic                    irq,
   input logic [9:0]              irq_pending,
   input logic [`TCI_TIMER_W-1:0] timer_value
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // ----------------------------------------------------------------
   // helper state: mask shadow, last timer value, cycles since a tick
   // ----------------------------------------------------------------
   logic [7:0]  mask_lo_r;
   logic [11:0] tv_r;
   logic [8:0]  gap_r;
   logic        seen_r;
   wire         mask_wr = reg_we && reg_addr == `TCI_REG_IRQ_MASK_LO;
   wire         tv_chg  = timer_value != tv_r;
   // shadow follows firmware writes so event checks know the mask
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mask_lo_r <= 8'h00;
         tv_r      <= 12'h000;
         gap_r     <= 9'h000;
         seen_r    <= 1'b0;
      end else begin
         if (mask_wr)
            mask_lo_r <= reg_wdata;
         tv_r   <= timer_value;
         gap_r  <= tv_chg ? 9'h000 : gap_r + 9'h001;
         seen_r <= seen_r | tv_chg;
      end
   end
   sequence s_rd_lo;
      reg_re && reg_addr == `TCI_REG_TIMER_LO;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_irq_is_or: assert property (irq == (|irq_pending))
      else $error("irq differs from or of pending bits");
   a_timer_step: assert property (tv_chg |-> timer_value == 12'(tv_r + 12'h001))
      else $error("timer did not advance by one");
   a_tick_period: assert property (tv_chg && seen_r |-> gap_r == 9'd199)
      else $error("tick spacing is not 200 cycles");
   a_tick_bound: assert property (gap_r <= 9'd200)
      else $error("timer stopped advancing");
   a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read reply");
   a_timer_read: assert property (s_rd_lo |=> reg_rdata == $past(timer_value[7:0])
      || reg_rdata == timer_value[7:0])
      else $error("timer low byte read wrong");
   a_mask_clear: assert property (mask_wr && reg_wdata == 8'h00
      |=> irq_pending[7:0] == 8'h00)
      else $error("cleared mask left pending bits");
   a_ep_event: assert property ((ep_done_evt & mask_lo_r[5:3]) != 3'h0 && !mask_wr
      |=> (irq_pending[5:3] & $past(ep_done_evt & mask_lo_r[5:3]))
          == $past(ep_done_evt & mask_lo_r[5:3]))
      else $error("endpoint event not pending");
   a_short_event: assert property (tv_chg && timer_value[6:0] == 7'h00 && mask_lo_r[1]
      && !mask_wr && !$past(mask_wr) |-> ##[0:2] irq_pending[1])
      else $error("128 us event missing");
   a_short_origin: assert property ($rose(irq_pending[1]) && !$past(mask_wr)
      |-> timer_value[6:0] == 7'h00)
      else $error("128 us event off boundary");
endmodule
bind tci_top tci_top_properties chk_i (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_we,
   .reg_re, .reg_rdata, .ep_done_evt, .irq, .irq_pending, .timer_value);

/* tci_top_test.sv */
// self-checking bench for the timer, capture and interrupt block
`include "tci_defs.vh"
module tci_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------
   logic       mclk, nrst, reg_we, reg_re, bus_reset_evt, wake_evt;
   logic [7:0] reg_addr, reg_wdata, port_zero_pins, port_one_pins, v, lo, hi;
   logic [2:0] ep_done_evt;
   logic [11:0] t0;
   wire  [7:0] reg_rdata;
   wire        irq;
   wire  [9:0] irq_pending;
   wire [11:0] timer_value;
   int         err_total = 0;
   int         cmp_count = 0;
   int         cyc = 0;
   tci_top uut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
      .port_zero_pins, .port_one_pins, .bus_reset_evt, .ep_done_evt, .wake_evt,
      .irq, .irq_pending, .timer_value);
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_we <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_re <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // drive pins, then allow the filter and capture to settle
   task automatic pins(input logic [7:0] p0, input logic [7:0] p1);
      @(posedge mclk);
      port_zero_pins <= p0;
      port_one_pins  <= p1;
      repeat (10) @(posedge mclk);
      #1;
   endtask
   // wait until the timer has just advanced
   task automatic sync_tick;
      logic [11:0] p;
      p = timer_value;
      for (int i = 0; i < 300 && timer_value === p; i++) @(posedge mclk);
   endtask
   task automatic test_done;
      if (err_total == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rd(`TCI_REG_CAP_CFG, v);
      chk(v, 12'h000);
      rd(`TCI_REG_IRQ_MASK_LO, v);
      chk(v, 12'h000);
      rd(8'h20, v);
      chk(v, 12'h000);
   endtask
   // two readings 1000 cycles apart differ by five ticks
   task automatic t_timer;
      rd(`TCI_REG_TIMER_LO, lo);
      rd(`TCI_REG_TIMER_HI, hi);
      t0 = {hi[3:0], lo};
      repeat (996) @(posedge mclk);
      rd(`TCI_REG_TIMER_LO, lo);
      rd(`TCI_REG_TIMER_HI, hi);
      chk({hi[3:0], lo} - t0, 12'h005);
   endtask
   task automatic t_capture;
      wr(`TCI_REG_CAP_CFG, 8'h90);
      wr(`TCI_REG_IRQ_MASK_LO, 8'hc0);
      sync_tick;
      rd(`TCI_REG_TIMER_LO, lo);
      pins(8'h01, 8'h00);
      rd(`TCI_REG_CAP_A_RISE, v);
      chk(v, lo);
      rd(`TCI_REG_CAP_B_RISE, v);
      chk(v, 12'h000);
      pins(8'h03, 8'h00);
      wr(`TCI_REG_CAP_CFG, 8'h94);
      sync_tick;
      rd(`TCI_REG_TIMER_LO, lo);
      rd(`TCI_REG_TIMER_HI, hi);
      t0 = {hi[3:0], lo};
      pins(8'h01, 8'h00);
      rd(`TCI_REG_CAP_B_FALL, v);
      chk(v, t0[11:4]);
      rd(`TCI_REG_CAP_STAT, v);
      chk(v, 12'h009);
      chk(irq_pending, 12'h0c0);
      wr(`TCI_REG_CAP_STAT, 8'h0f);
      wr(`TCI_REG_IRQ_STAT_LO, 8'hc0);
      rd(`TCI_REG_CAP_STAT, v);
      chk(v, 12'h000);
      chk(irq, 1'b0);
   endtask
   task automatic t_periodic;
      wr(`TCI_REG_IRQ_MASK_LO, 8'h02);
      for (int i = 0; i < 26000 && irq !== 1'b1; i++) @(posedge mclk);
      rd(`TCI_REG_TIMER_LO, lo);
      chk(lo & 8'h7f, 12'h000);
      chk(irq_pending, 12'h002);
      wr(`TCI_REG_IRQ_MASK_LO, 8'h00);
      wr(`TCI_REG_IRQ_STAT_LO, 8'h02);
      repeat (26000) @(posedge mclk);
      rd(`TCI_REG_IRQ_STAT_LO, v);
      chk(v, 12'h000);
   endtask
   task automatic t_gpio;
      wr(`TCI_REG_P1_MASK, 8'h08);
      wr(`TCI_REG_P1_POL, 8'h00);
      wr(`TCI_REG_IRQ_MASK_HI, 8'h02);
      pins(8'h01, 8'h20);
      pins(8'h01, 8'h00);
      chk(irq_pending, 12'h000);
      pins(8'h01, 8'h08);
      chk(irq_pending, 12'h000);
      pins(8'h01, 8'h00);
      chk(irq_pending, 12'h200);
      wr(`TCI_REG_IRQ_STAT_HI, 8'h02);
      wr(`TCI_REG_P1_POL, 8'h08);
      pins(8'h01, 8'h08);
      chk(irq_pending, 12'h200);
      wr(`TCI_REG_IRQ_STAT_HI, 8'h02);
   endtask
   task automatic t_events;
      @(posedge mclk);
      wake_evt <= 1'b1;
      @(posedge mclk);
      wake_evt <= 1'b0;
      @(posedge mclk);
      #1 chk(irq, 1'b0);
      wr(`TCI_REG_IRQ_MASK_HI, 8'h03);
      chk(irq_pending, 12'h100);
      wr(`TCI_REG_IRQ_MASK_LO, 8'h39);
      @(posedge mclk);
      bus_reset_evt <= 1'b1;
      ep_done_evt   <= 3'h7;
      @(posedge mclk);
      bus_reset_evt <= 1'b0;
      ep_done_evt   <= 3'h0;
      @(posedge mclk);
      #1 chk(irq_pending, 12'h139);
      wr(`TCI_REG_IRQ_STAT_LO, 8'hff);
      wr(`TCI_REG_IRQ_STAT_HI, 8'h03);
      chk(irq_pending, 12'h000);
      chk(irq, 1'b0);
   endtask
   // ----------------------------------------------------------------
   // clock, timeout and main sequence
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 90000) begin
         err_total++;
         test_done;
      end
   end
   initial begin
      nrst = 1'b0;
      reg_we = 1'b0;
      reg_re = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      port_zero_pins = 8'h00;
      port_one_pins = 8'h00;
      bus_reset_evt = 1'b0;
      ep_done_evt = 3'h0;
      wake_evt = 1'b0;
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      t_reset;
      t_timer;
      t_capture;
      t_periodic;
      t_gpio;
      t_events;
      test_done;
   end
endmodule
